//--- rdds_pkg.sv
// constants and types shared by the rotating default display selector
package rdds_pkg;
  localparam int RDDS_POINTS = 16;
  localparam int RDDS_GROUPS = 6;
  localparam int RDDS_CHARS = 16;
  localparam int RDDS_PT_W = 4;
  localparam int RDDS_CH_W = 4;
  localparam int RDDS_GRP_W = 3;
  localparam int RDDS_ADDR_W = 9;
  localparam int RDDS_DATA_W = 8;
  localparam int RDDS_OPTO_X = 6;
  localparam int RDDS_LOCAL_N = 4;
  localparam int RDDS_LATCH_N = 4;
  localparam int RDDS_REMOTE_N = 8;
  localparam int RDDS_GRPIND_N = 6;
  localparam int RDDS_WORD_W = 2 + RDDS_OPTO_X + RDDS_LOCAL_N + RDDS_LATCH_N + RDDS_REMOTE_N
                               + RDDS_GRPIND_N;
  localparam int RDDS_SLOTS = 2 * RDDS_POINTS;
  localparam int RDDS_DWELL_W = 8;
  localparam int RDDS_TICK_W = 25;
  // dwell setting counts in seconds
  localparam int RDDS_CLK_HZ = 25_000_000;
  localparam int RDDS_TICK_MS = 1000;
  localparam int RDDS_TICK_CYCLES = RDDS_CLK_HZ / 1000 * RDDS_TICK_MS;
  localparam logic [RDDS_DATA_W-1:0] RDDS_CHAR_SPACE = 8'h20;
  localparam logic [RDDS_DATA_W-1:0] RDDS_CHAR_NUL = 8'h00;
  localparam logic [RDDS_PT_W-1:0] RDDS_PT_LAST = 4'hF;
  localparam logic [RDDS_DATA_W-1:0] RDDS_DATA_RST = 8'h00;
  typedef enum logic [0:0] {
    RDDS_IDLE = 1'b0,
    RDDS_SHOW = 1'b1
  } rdds_state_e;
endpackage : rdds_pkg

//--- rdds_text_mem.sv
// text store: one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module rdds_text_mem #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input wire logic clk, // block clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [AW-1:0] wr_addr, // write address
  input wire logic [DW-1:0] wr_data, // write data
  input wire logic rd_a_en, // port a read strobe
  input wire logic [AW-1:0] rd_a_addr, // port a address
  output logic [DW-1:0] rd_a_data, // port a data, one cycle later
  input wire logic [AW-1:0] rd_b_addr, // port b address, read every cycle
  output logic [DW-1:0] rd_b_data // port b data, one cycle later
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // storage write, no reset on the array
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read ports, old data on a same-cycle collision
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      if (rd_a_en) begin
        rd_a_data <= mem[rd_a_addr];
      end
      rd_b_data <= mem[rd_b_addr];
    end
  end
endmodule : rdds_text_mem
`default_nettype wire

//--- rdds_top.sv
// rotating default display selector: point evaluation, text store and rotation
//
// Overview of operation
// - sixteen display points, indexed 0 to 15, each feed the rotation
// - each point owns a true slot text and a false slot text
// - point at 1 shows true slot text, at 0 shows false slot text
// - a blank selected slot shows nothing for that point
// - a point tied to constant keeps the same slot in rotation permanently
// - expressions combine opto inputs, local, latch, remote and group bits
// - each setting group has its own expressions; active group one evaluated
// - one copy of every text, shared by all groups
// - non-blank selected messages cycle with the global scroll dwell time
`timescale 1ns/1ps
`default_nettype none
module rdds_top #(
  parameter int TICK_CYCLES = rdds_pkg::RDDS_TICK_CYCLES
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic breaker_status_input, // opto input pin
  input wire logic reclose_enable_input, // opto input pin
  input wire logic [rdds_pkg::RDDS_OPTO_X-1:0] opto_extra_input, // further opto pins
  input wire logic [rdds_pkg::RDDS_LOCAL_N-1:0] local_bit, // local bits
  input wire logic [rdds_pkg::RDDS_LATCH_N-1:0] latch_bit, // latch bits
  input wire logic [rdds_pkg::RDDS_REMOTE_N-1:0] remote_bit, // remote bits
  input wire logic [rdds_pkg::RDDS_GRPIND_N-1:0] group_indicator, // group indicators
  input wire logic [rdds_pkg::RDDS_GRP_W-1:0] active_group, // active group, 0 based
  input wire logic [rdds_pkg::RDDS_GROUPS*rdds_pkg::RDDS_POINTS*rdds_pkg::RDDS_WORD_W-1:0]
    display_point_expr_mask, // or-mask per group and point
  input wire logic [rdds_pkg::RDDS_GROUPS*rdds_pkg::RDDS_POINTS-1:0]
    display_point_expr_invert, // output inversion per group and point
  input wire logic [rdds_pkg::RDDS_DWELL_W-1:0] scroll_dwell_setting, // dwell in seconds
  input wire logic text_wr_en, // text write strobe
  input wire logic [rdds_pkg::RDDS_PT_W-1:0] text_wr_point, // point 0..15
  input wire logic text_wr_slot, // 1 true slot, 0 false slot
  input wire logic [rdds_pkg::RDDS_CH_W-1:0] text_wr_char, // character index
  input wire logic [rdds_pkg::RDDS_DATA_W-1:0] text_wr_data, // character code
  input wire logic text_show_command, // text read strobe
  input wire logic [rdds_pkg::RDDS_PT_W-1:0] text_rd_point, // point to read
  input wire logic text_rd_slot, // slot to read
  input wire logic [rdds_pkg::RDDS_CH_W-1:0] text_rd_char, // character to read
  output logic [rdds_pkg::RDDS_DATA_W-1:0] text_rd_data, // read character
  output logic text_rd_valid, // read data valid pulse
  input wire logic [rdds_pkg::RDDS_CH_W-1:0] disp_char_idx, // display character fetch
  output logic [rdds_pkg::RDDS_DATA_W-1:0] disp_char_data, // fetched character
  output logic disp_valid, // a message is shown
  output logic [rdds_pkg::RDDS_PT_W-1:0] disp_point, // shown point, 0 based
  output logic disp_slot, // shown slot
  output logic disp_new_msg // pulse on each rotation step
);
  import rdds_pkg::*;

  localparam logic [RDDS_TICK_W-1:0] TICK_LAST = RDDS_TICK_W'(TICK_CYCLES - 1);

  logic rst_s1_reg, rst_s2_reg;
  logic rst_ok_n;
  logic [RDDS_OPTO_X+1:0] opto_s1_reg, opto_s2_reg;
  logic [RDDS_WORD_W-1:0] relay_word;
  logic [RDDS_GRP_W-1:0] grp_pick;
  logic [RDDS_POINTS-1:0] dp_value, dp_val_reg, dp_val_prev;
  logic [RDDS_SLOTS*RDDS_CHARS-1:0] char_nb_reg;
  logic [RDDS_SLOTS-1:0] slot_nb;
  logic [RDDS_POINTS-1:0] elig;
  logic [RDDS_ADDR_W-1:0] wr_addr, rd_addr, disp_addr;
  logic wr_nb;
  rdds_state_e state_reg, state_next;
  logic [RDDS_PT_W-1:0] point_reg, point_next, search_base, next_pt;
  logic next_found;
  logic cur_elig;
  logic [RDDS_TICK_W-1:0] tick_cnt_reg;
  logic tick;
  logic [RDDS_DWELL_W-1:0] dwell_cnt_reg, dwell_last;
  logic dwell_done;
  logic step;
  logic slot_reg, new_reg, valid_reg, rd_v_reg;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_ok_n = rst_s2_reg;

  // opto pins pass two flops before use
  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      opto_s1_reg <= '0;
      opto_s2_reg <= '0;
    end else begin
      opto_s1_reg <= {opto_extra_input, reclose_enable_input, breaker_status_input};
      opto_s2_reg <= opto_s1_reg;
    end
  end

  // relay word and active group selection
  assign relay_word = {group_indicator, remote_bit, latch_bit, local_bit, opto_s2_reg};
  assign grp_pick = (active_group < RDDS_GRP_W'(RDDS_GROUPS)) ? active_group : '0;

  // per point: value = invert xor (any masked relay bit); zero mask gives a constant
  genvar gp;
  generate
    for (gp = 0; gp < RDDS_POINTS; gp++) begin : g_point
      logic [RDDS_WORD_W-1:0] mask_w;
      logic inv_w;
      assign mask_w = display_point_expr_mask[(int'(grp_pick)*RDDS_POINTS+gp)*RDDS_WORD_W +:
                      RDDS_WORD_W];
      assign inv_w = display_point_expr_invert[int'(grp_pick)*RDDS_POINTS+gp];
      assign dp_value[gp] = inv_w ^ (|(relay_word & mask_w));
      // eligible when the slot picked by the current value is not blank
      assign elig[gp] = slot_nb[2*gp + int'(dp_val_reg[gp])];
    end
  endgenerate

  // point values re-evaluated every cycle
  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      dp_val_reg <= '0;
      dp_val_prev <= '0;
    end else begin
      dp_val_reg <= dp_value;
      dp_val_prev <= dp_val_reg;
    end
  end

  // text addressing: point, slot, character; one copy for all groups
  assign wr_addr = {text_wr_point, text_wr_slot, text_wr_char};
  assign rd_addr = {text_rd_point, text_rd_slot, text_rd_char};
  assign disp_addr = {point_reg, slot_reg, disp_char_idx};
  assign wr_nb = (text_wr_data != RDDS_CHAR_SPACE) && (text_wr_data != RDDS_CHAR_NUL);

  // per-character non-blank flags track each write
  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      char_nb_reg <= '0;
    end else if (text_wr_en) begin
      char_nb_reg[wr_addr] <= wr_nb;
    end
  end

  // a slot is blank when all its characters are blank
  genvar gs;
  generate
    for (gs = 0; gs < RDDS_SLOTS; gs++) begin : g_slot
      assign slot_nb[gs] = |char_nb_reg[gs*RDDS_CHARS +: RDDS_CHARS];
    end
  endgenerate

  rdds_text_mem #(
    .AW(RDDS_ADDR_W),
    .DW(RDDS_DATA_W)
  ) u_mem (
    .clk(ref_clk),
    .rst_n(rst_ok_n),
    .wr_en(text_wr_en),
    .wr_addr(wr_addr),
    .wr_data(text_wr_data),
    .rd_a_en(text_show_command),
    .rd_a_addr(rd_addr),
    .rd_a_data(text_rd_data),
    .rd_b_addr(disp_addr),
    .rd_b_data(disp_char_data)
  );

  // one-second tick divider and dwell counter
  assign tick = (tick_cnt_reg == TICK_LAST);
  assign dwell_last = (scroll_dwell_setting == '0) ? '0 : scroll_dwell_setting - 1'b1;
  assign dwell_done = tick && (dwell_cnt_reg >= dwell_last);
  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      tick_cnt_reg <= '0;
      dwell_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
      if (step || state_reg == RDDS_IDLE) begin
        dwell_cnt_reg <= '0;
      end else if (tick) begin
        dwell_cnt_reg <= dwell_cnt_reg + 1'b1;
      end
    end
  end

  // ascending search for the next eligible point with wrap
  assign search_base = (state_reg == RDDS_IDLE) ? RDDS_PT_LAST : point_reg;
  always_comb begin
    logic [RDDS_PT_W-1:0] idx;
    idx = '0;
    next_found = 1'b0;
    next_pt = search_base;
    for (int k = 1; k <= RDDS_POINTS; k++) begin
      idx = search_base + RDDS_PT_W'(k);
      if (!next_found && elig[idx]) begin
        next_found = 1'b1;
        next_pt = idx;
      end
    end
  end

  // rotation state machine
  assign cur_elig = elig[point_reg];
  assign step = (state_reg == RDDS_IDLE) ? next_found : (!cur_elig || dwell_done);
  always_comb begin
    state_next = state_reg;
    point_next = point_reg;
    unique case (state_reg)
      RDDS_IDLE: begin
        if (next_found) begin
          state_next = RDDS_SHOW;
          point_next = next_pt;
        end
      end
      RDDS_SHOW: begin
        if (step) begin
          state_next = next_found ? RDDS_SHOW : RDDS_IDLE;
          point_next = next_found ? next_pt : point_reg;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      state_reg <= RDDS_IDLE;
      point_reg <= '0;
      slot_reg <= 1'b0;
      new_reg <= 1'b0;
      valid_reg <= 1'b0;
      rd_v_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      point_reg <= point_next;
      slot_reg <= dp_val_reg[point_next];
      new_reg <= step && next_found;
      valid_reg <= (state_next == RDDS_SHOW);
      rd_v_reg <= text_show_command;
    end
  end

  assign disp_valid = valid_reg;
  assign disp_point = point_reg;
  assign disp_slot = slot_reg;
  assign disp_new_msg = new_reg;
  assign text_rd_valid = rd_v_reg;

  // checks
  a_slot_follows: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    disp_valid |-> disp_slot == dp_val_prev[disp_point])
    else $error("shown slot differs from point value");
  a_blank_skip: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    (state_reg == RDDS_SHOW && !cur_elig) |=> (!disp_valid || $changed(point_reg)))
    else $error("blank message kept in rotation");
  a_const_point: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    ($past(g_point[0].mask_w) == '0) |-> dp_val_reg[0] == $past(g_point[0].inv_w))
    else $error("constant point not constant");
  a_dwell_hold: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    (state_reg == RDDS_SHOW && cur_elig && !dwell_done) |=> $stable(point_reg))
    else $error("message left before dwell end");
  a_dwell_bound: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    (dwell_cnt_reg <= dwell_last) ##1 $stable(scroll_dwell_setting) |->
    dwell_cnt_reg <= dwell_last)
    else $error("dwell counter overran setting");
  a_next_order: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    (step && next_found) |=> point_reg == $past(next_pt) && disp_new_msg)
    else $error("rotation did not take next eligible point");
  a_idle_empty: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    (elig == '0) |=> !disp_valid)
    else $error("message shown with nothing eligible");
  a_eval_cycle: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    $changed(dp_value) |=> dp_val_reg == $past(dp_value))
    else $error("point value not re-evaluated");
  a_text_shared: assert property (@(posedge ref_clk) disable iff (!rst_ok_n)
    (text_wr_en ##1 (text_show_command && !text_wr_en && rd_addr == $past(wr_addr)))
    |=> text_rd_valid && text_rd_data == $past(text_wr_data, 2))
    else $error("text readback mismatch");
endmodule : rdds_top
`default_nettype wire

//--- rdds_disp_model.sv
// front-panel display model: fetches the first character of each new message
`timescale 1ns/1ps
`default_nettype none
module rdds_disp_model (
  input wire logic clk, // block clock
  input wire logic new_msg, // rotation step pulse
  input wire logic [3:0] point, // shown point
  input wire logic slot, // shown slot
  input wire logic [7:0] char_data, // fetched character
  output logic [3:0] char_idx // character fetch index
);
  logic pend;
  logic [4:0] ps;
  logic [12:0] shown[$];
  // the panel reads only the first character of each message
  assign char_idx = 4'h0;
  // log point, slot and first character once the fetch has landed
  always @(posedge clk) begin
    if (pend) begin
      shown.push_back({ps, char_data});
    end
    pend <= new_msg;
    ps <= {point, slot};
  end
endmodule : rdds_disp_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the rotating default display selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rdds_pkg::*;
  localparam int TK = 8;
  localparam int MW = RDDS_GROUPS * RDDS_POINTS * RDDS_WORD_W;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic [29:0] rw = '0;
  logic [2:0] grp = '0;
  logic [MW-1:0] mask = '0;
  logic [95:0] inv = '0;
  logic [7:0] dwell = 8'h01;
  logic wr_en = 0, wr_slot = 0, rd_cmd = 0, rd_slot = 0;
  logic [3:0] wr_pt = '0, wr_ch = '0, rd_pt = '0, rd_ch = '0, idx, d_pt;
  logic [7:0] wr_data = '0, rd_data, ch_data;
  logic rd_valid, d_valid, d_slot, d_new;
  int errors = 0, comparisons = 0;
  rdds_top #(.TICK_CYCLES(TK)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .breaker_status_input(rw[0]), .reclose_enable_input(rw[1]), .opto_extra_input(rw[7:2]),
    .local_bit(rw[11:8]), .latch_bit(rw[15:12]), .remote_bit(rw[23:16]),
    .group_indicator(rw[29:24]), .active_group(grp), .display_point_expr_mask(mask),
    .display_point_expr_invert(inv), .scroll_dwell_setting(dwell), .text_wr_en(wr_en),
    .text_wr_point(wr_pt), .text_wr_slot(wr_slot), .text_wr_char(wr_ch),
    .text_wr_data(wr_data), .text_show_command(rd_cmd), .text_rd_point(rd_pt),
    .text_rd_slot(rd_slot), .text_rd_char(rd_ch), .text_rd_data(rd_data),
    .text_rd_valid(rd_valid), .disp_char_idx(idx), .disp_char_data(ch_data),
    .disp_valid(d_valid), .disp_point(d_pt), .disp_slot(d_slot), .disp_new_msg(d_new));
  rdds_disp_model u_disp (.clk(ref_clk), .new_msg(d_new), .point(d_pt), .slot(d_slot),
    .char_data(ch_data), .char_idx(idx));
  // 25 MHz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  // full text: first character given, the rest spaces
  task automatic txt(input int p, input logic s, input logic [7:0] c);
    for (int i = 0; i < 16; i++) begin
      wr_en = 1'b1;
      wr_pt = 4'(p);
      wr_slot = s;
      wr_ch = 4'(i);
      wr_data = (i == 0) ? c : RDDS_CHAR_SPACE;
      cyc(1);
    end
    wr_en = 1'b0;
    cyc(1);
  endtask : txt
  task automatic rd(input int p, input logic s, input int ch, input logic [7:0] exp);
    rd_cmd = 1'b1;
    rd_pt = 4'(p);
    rd_slot = s;
    rd_ch = 4'(ch);
    cyc(1);
    rd_cmd = 1'b0;
    chk("text_rd_valid", rd_valid, 1'b1);
    chk("text_rd_data", rd_data, exp);
    cyc(1);
    chk("text_rd_valid", rd_valid, 1'b0);
  endtask : rd
  task automatic setp(input int g, input int p, input logic [29:0] m, input logic iv);
    mask[(g * 16 + p) * 30 +: 30] = m;
    inv[g * 16 + p] = iv;
  endtask : setp
  task automatic pop(output logic [12:0] e);
    int n = 0;
    while (u_disp.shown.size() == 0 && n < 100) begin
      cyc(1);
      n++;
    end
    e = '1;
    if (u_disp.shown.size() > 0) begin
      e = u_disp.shown.pop_front();
    end
  endtask : pop
  // next showing of point p after the queue is flushed
  task automatic look(input int p, input logic s, input logic [7:0] c);
    logic [12:0] e;
    u_disp.shown.delete();
    for (int j = 0; j < 4; j++) begin
      pop(e);
      if (e[12:9] == p) break;
    end
    chk("disp_point", e[12:9], p);
    chk("disp_slot", e[8], s);
    chk("disp_char_data", e[7:0], c);
  endtask : look
  task automatic t_text();
    txt(0, 1'b1, 8'h54);
    txt(0, 1'b0, 8'h46);
    // single write followed at once by a read of the same character
    wr_en = 1'b1;
    wr_pt = 4'h0;
    wr_slot = 1'b1;
    wr_ch = 4'h2;
    wr_data = 8'h41;
    cyc(1);
    wr_en = 1'b0;
    rd(0, 1'b1, 2, 8'h41);
    rd(0, 1'b1, 0, 8'h54);
    rd(0, 1'b1, 1, 8'h20);
    rd(0, 1'b0, 0, 8'h46);
    look(0, 1'b0, 8'h46);
  endtask : t_text
  // every kind of relay bit steers the point, re-evaluated live
  task automatic t_expr();
    int bits[7] = '{0, 1, 2, 8, 12, 16, 24};
    foreach (bits[i]) begin
      setp(0, 0, 30'(1) << bits[i], 1'b0);
      rw = 30'(1) << bits[i];
      cyc(12);
      look(0, 1'b1, 8'h54);
      rw = '0;
      cyc(12);
      look(0, 1'b0, 8'h46);
    end
  endtask : t_expr
  task automatic t_blank();
    setp(0, 0, 30'h1, 1'b0);
    txt(0, 1'b0, RDDS_CHAR_SPACE);
    cyc(12);
    chk("disp_valid", d_valid, 1'b0);
    rw[0] = 1'b1;
    cyc(12);
    look(0, 1'b1, 8'h54);
  endtask : t_blank
  // constant points join the ascending rotation and wrap
  task automatic t_order();
    logic [12:0] e;
    logic [12:0] ex[3] = '{{4'd0, 1'b1, 8'h54}, {4'd4, 1'b1, 8'h4c}, {4'd15, 1'b0, 8'h5a}};
    int k = 0;
    setp(0, 4, '0, 1'b1);
    txt(4, 1'b1, 8'h4c);
    setp(0, 15, '0, 1'b0);
    txt(15, 1'b0, 8'h5a);
    cyc(12);
    u_disp.shown.delete();
    pop(e);
    for (int j = 0; j < 3; j++) begin
      if (e == ex[j]) k = j;
    end
    for (int j = 1; j < 6; j++) begin
      pop(e);
      chk("rotation", e, ex[(k + j) % 3]);
    end
  endtask : t_order
  task automatic t_group();
    txt(0, 1'b0, 8'h46);
    setp(1, 0, 30'h100, 1'b0);
    grp = 3'h1;
    cyc(12);
    look(0, 1'b0, 8'h46);
    rw[8] = 1'b1;
    cyc(12);
    look(0, 1'b1, 8'h54);
    rw[0] = 1'b0;
    grp = 3'h6;
    cyc(12);
    look(0, 1'b0, 8'h46);
    look(4, 1'b1, 8'h4c);
    look(15, 1'b0, 8'h5a);
  endtask : t_group
  task automatic gap(output int n);
    n = 1;
    cyc(1);
    while (d_new !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
  endtask : gap
  task automatic t_dwell();
    int d[3] = '{0, 1, 3};
    int n;
    foreach (d[i]) begin
      dwell = 8'(d[i]);
      repeat (3) gap(n);
      chk("dwell", n, (d[i] == 0 ? 1 : d[i]) * TK);
    end
  endtask : t_dwell
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    cyc(6);
    rst_n = 1'b1;
    cyc(3);
    chk("disp_valid", d_valid, 1'b0);
    t_text();
    t_expr();
    t_blank();
    t_order();
    t_group();
    t_dwell();
    tally_and_finish();
  end
  // watchdog
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
